/* src/ovp_cfg.svh */
`ifndef OVP_CFG_SVH
`define OVP_CFG_SVH

// register byte addresses
`define ADDR_CTRL 8'h00
`define ADDR_THRESH 8'h04
`define ADDR_HYST 8'h08
`define ADDR_DELAY 8'h0c
`define ADDR_STATUS 8'h10

// control register fields
`define CTRL_ENABLE_BIT 0
`define CTRL_STONLY_BIT 1
`define CTRL_MV_BIT 2

// status register fields
`define STAT_START_LSB 0
`define STAT_TRIP_LSB 3
`define STAT_GENST_BIT 6
`define STAT_GENTR_BIT 7
`define STAT_BLOCK_BIT 8

// reset values and setting ranges
`define RST_ENABLE 1'h0
`define RST_STONLY 1'h0
`define RST_MV 1'h0
`define RST_THRESH 8'h6e
`define THRESH_MIN 8'h1e
`define THRESH_MAX 8'h82
`define RST_HYST 4'h5
`define HYST_MIN 4'h1
`define HYST_MAX 4'ha
`define RST_DELAY 16'h0064
`define DELAY_MAX 16'hea60

// percent base
`define PERCENT 100

// timing
`define CLK_PERIOD_NS 40
`define TIMER_STEP_MS 1
`define CYCLES_PER_MS ((`TIMER_STEP_MS * 1000000) / `CLK_PERIOD_NS)

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* src/ovp_pkg.sv */
package ovp_pkg;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_STARTED = 2'b01,
		PH_TRIPPED = 2'b10
	} phase_state_e;

	typedef struct packed {
		logic function_enable_setting;
		logic start_without_trip_select;
		logic line_to_line_mode;
		logic [7:0] start_threshold_percent;
		logic [3:0] dropoff_hysteresis_percent;
		logic [15:0] operate_delay_ms;
	} settings_s;

	typedef struct packed {
		logic started;
		logic internal_trip;
	} phase_status_s;

endpackage

/* src/ovp_ms_tick.sv */
`timescale 1ns/1ps
module ovp_ms_tick
	import ovp_pkg::*;
#(
	parameter int CYCLES = 25000
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// holds the prescaler at zero
	input wire logic clear,
	// one pulse per elapsed millisecond
	output logic tick
);

	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] cnt_q;
	wire last = (cnt_q == CW'(CYCLES - 1));

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else if (clear) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else begin
			cnt_q <= last ? '0 : CW'(cnt_q + 1'b1);
			tick <= last;
		end
	end

endmodule

/* src/ovp_phase.sv */
`timescale 1ns/1ps
module ovp_phase
	import ovp_pkg::*;
#(
	parameter int LW = 32
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// function disabled or blocked
	input wire logic clear,
	// scaled magnitude and levels
	input wire logic [LW-1:0] mag_scaled,
	input wire logic [LW-1:0] pickup_level,
	input wire logic [LW-1:0] dropoff_level,
	// timing
	input wire logic [15:0] delay_ms,
	input wire logic ms_tick,
	// state out
	output phase_status_s status
);

	phase_state_e state_q;
	phase_state_e state_d;
	logic [15:0] ms_q;
	logic [15:0] ms_d;

	wire above = (mag_scaled > pickup_level);
	wire below = (mag_scaled < dropoff_level);
	wire [15:0] ms_inc = 16'(ms_q + 16'h0001);

	always_comb begin
		state_d = state_q;
		ms_d = ms_q;
		case (state_q)
			PH_IDLE: begin
				ms_d = 16'h0000;
				if (above) begin // R4
					state_d = (delay_ms == 16'h0000) ? PH_TRIPPED : PH_STARTED;
				end
			end
			PH_STARTED: begin
				if (below) begin // R5
					state_d = PH_IDLE;
					ms_d = 16'h0000; // R13
				end else if (ms_tick) begin
					ms_d = ms_inc;
					if (ms_inc >= delay_ms) begin // R7
						state_d = PH_TRIPPED;
					end
				end
			end
			PH_TRIPPED: begin
				if (below) begin // R5
					state_d = PH_IDLE;
				end
			end
			default: begin
				state_d = PH_IDLE;
				ms_d = 16'h0000;
			end
		endcase
		if (clear) begin
			state_d = PH_IDLE;
			ms_d = 16'h0000;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= PH_IDLE;
			ms_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			ms_q <= ms_d;
		end
	end

	assign status.started = (state_q != PH_IDLE);
	assign status.internal_trip = (state_q == PH_TRIPPED);

endmodule

/* src/ovp_top.sv */
`timescale 1ns/1ps
`include "ovp_cfg.svh"

// Summary of operation
// R1: upstream supplies RMS fundamental magnitudes; no Fourier work is done here.
// R2: line-to-line mode: inputs and flags refer to phase pairs instead.
// R3: operation setting off/on, off at reset; off suppresses all outputs.
// R4: phase starts when magnitude exceeds threshold percent, 30..130, default 110.
// R5: started phase drops only below threshold by hysteresis percent, 1..10, def 5.
// R6: operate delay in milliseconds, 0..60000, default 100.
// R7: phase internal trip once started for the full operate delay.
// R8: start-only setting, default 0; at 1 the trip is suppressed.
// R9: general start is the OR of the three phase start flags.
// R10: user block input suppresses every start and trip output.
// R11: phase trips stay internal; only general trip leaves the block. Here the phase trips are also readable in status bits 3..5.
// R12: each phase evaluates its started state independently.
// R13: phase delay timer restarts from zero when its start drops early.
// R14: general trip is OR of phase trips, gated by start-only, enable, block.
module ovp_top
	import ovp_pkg::*;
#(
	parameter int MAG_W = 16,
	parameter logic [15:0] NOMINAL_CODE = 16'h2710,
	parameter int CYCLES_PER_MS = `CYCLES_PER_MS
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// measured magnitudes, NOMINAL_CODE equals 100 percent
	input wire logic [MAG_W-1:0] phase_a_rms_magnitude,
	input wire logic [MAG_W-1:0] phase_b_rms_magnitude,
	input wire logic [MAG_W-1:0] phase_c_rms_magnitude,
	// user blocking
	input wire logic user_block_input,
	// protection outputs
	output logic phase_a_start_flag,
	output logic phase_b_start_flag,
	output logic phase_c_start_flag,
	output logic any_phase_start,
	output logic overall_trip_command
);

	// wide enough for magnitude times 10000 and threshold products
	localparam int LW = MAG_W + 32;
	localparam logic [LW-1:0] PCT = LW'(`PERCENT);

	settings_s cfg_q;

	// write channel holding registers
	logic aw_have_q;
	logic w_have_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic [1:0] bresp_q;
	logic bvalid_q;

	// read channel registers
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic rvalid_q;

	// output registers
	logic [2:0] start_q;
	logic gen_start_q;
	logic gen_trip_q;

	// per-phase signals
	logic [MAG_W-1:0] mag [3];
	phase_status_s ph [3];
	logic [2:0] ph_started;
	logic [2:0] ph_trip;

	assign mag[0] = phase_a_rms_magnitude; // R1
	assign mag[1] = phase_b_rms_magnitude;
	assign mag[2] = phase_c_rms_magnitude;

	// the function is live only when enabled and not blocked
	wire active = cfg_q.function_enable_setting & ~user_block_input; // R3 R10

	// levels in units of magnitude times percent squared
	wire [LW-1:0] thr_w = LW'(cfg_q.start_threshold_percent);
	wire [LW-1:0] hyst_w = LW'(cfg_q.dropoff_hysteresis_percent);
	wire [LW-1:0] nom_w = LW'(NOMINAL_CODE);
	wire [LW-1:0] pickup_level = LW'(thr_w * nom_w * PCT); // R4
	wire [LW-1:0] dropoff_level = LW'(thr_w * nom_w * (PCT - hyst_w)); // R5

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_phase
			logic tick;
			wire [LW-1:0] mag_scaled = LW'(LW'(mag[g]) * PCT * PCT);

			// prescaler restarts with each start so the delay is never short
			ovp_ms_tick #(
				.CYCLES(CYCLES_PER_MS)
			) u_tick (
				.ref_clk(ref_clk),
				.rst(rst),
				.clear(~ph[g].started), // R13
				.tick(tick)
			);

			ovp_phase #(
				.LW(LW)
			) u_phase ( // R12
				.ref_clk(ref_clk),
				.rst(rst),
				.clear(~active), // R3 R10
				.mag_scaled(mag_scaled),
				.pickup_level(pickup_level),
				.dropoff_level(dropoff_level),
				.delay_ms(cfg_q.operate_delay_ms), // R6
				.ms_tick(tick),
				.status(ph[g])
			);

			assign ph_started[g] = ph[g].started;
			assign ph_trip[g] = ph[g].internal_trip;
		end
	endgenerate

	// output decision
	wire [2:0] start_d = ph_started & {3{active}}; // R3 R10
	wire trip_allowed = active & ~cfg_q.start_without_trip_select; // R8
	wire gen_trip_d = (|ph_trip) & trip_allowed; // R14

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			start_q <= 3'h0;
			gen_start_q <= 1'h0;
			gen_trip_q <= 1'h0;
		end else begin
			start_q <= start_d;
			gen_start_q <= |start_d; // R9
			gen_trip_q <= gen_trip_d; // R11
		end
	end

	// in line-to-line mode a, b, c stand for the pairs ab, bc, ca
	assign phase_a_start_flag = start_q[0]; // R2
	assign phase_b_start_flag = start_q[1];
	assign phase_c_start_flag = start_q[2];
	assign any_phase_start = gen_start_q;
	assign overall_trip_command = gen_trip_q; // R11

	// axi write path: address and data accepted in either order
	assign s_axi_awready = ~aw_have_q & ~bvalid_q;
	assign s_axi_wready = ~w_have_q & ~bvalid_q;
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire wr_fire = aw_have_q & w_have_q & ~bvalid_q;

	wire wr_ctrl = wr_fire & (aw_addr_q == `ADDR_CTRL);
	wire wr_thresh = wr_fire & (aw_addr_q == `ADDR_THRESH);
	wire wr_hyst = wr_fire & (aw_addr_q == `ADDR_HYST);
	wire wr_delay = wr_fire & (aw_addr_q == `ADDR_DELAY);
	wire wr_status = wr_fire & (aw_addr_q == `ADDR_STATUS);
	wire wr_mapped = wr_ctrl | wr_thresh | wr_hyst | wr_delay | wr_status;

	// out-of-range settings saturate so the logic never sees them
	wire [7:0] thr_wr = w_data_q[7:0];
	wire [7:0] thr_sat = (thr_wr < `THRESH_MIN) ? `THRESH_MIN :
		(thr_wr > `THRESH_MAX) ? `THRESH_MAX : thr_wr;
	wire [7:0] hyst_wr = w_data_q[7:0];
	wire [3:0] hyst_sat = (hyst_wr < 8'(`HYST_MIN)) ? `HYST_MIN :
		(hyst_wr > 8'(`HYST_MAX)) ? `HYST_MAX : hyst_wr[3:0];
	wire [15:0] dly_wr = {
		w_strb_q[1] ? w_data_q[15:8] : cfg_q.operate_delay_ms[15:8],
		w_strb_q[0] ? w_data_q[7:0] : cfg_q.operate_delay_ms[7:0]
	};
	wire [15:0] dly_sat = (dly_wr > `DELAY_MAX) ? `DELAY_MAX : dly_wr;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			aw_have_q <= 1'h0;
			w_have_q <= 1'h0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_have_q <= 1'h1;
				aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
			end else if (wr_fire) begin
				aw_have_q <= 1'h0;
			end
			if (w_take) begin
				w_have_q <= 1'h1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_have_q <= 1'h0;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bvalid_q <= 1'h0;
			bresp_q <= `RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'h1;
			bresp_q <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'h0;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// settings registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cfg_q.function_enable_setting <= `RST_ENABLE; // R3
			cfg_q.start_without_trip_select <= `RST_STONLY; // R8
			cfg_q.line_to_line_mode <= `RST_MV;
			cfg_q.start_threshold_percent <= `RST_THRESH; // R4
			cfg_q.dropoff_hysteresis_percent <= `RST_HYST; // R5
			cfg_q.operate_delay_ms <= `RST_DELAY; // R6
		end else begin
			if (wr_ctrl & w_strb_q[0]) begin
				cfg_q.function_enable_setting <= w_data_q[`CTRL_ENABLE_BIT];
				cfg_q.start_without_trip_select <= w_data_q[`CTRL_STONLY_BIT];
				cfg_q.line_to_line_mode <= w_data_q[`CTRL_MV_BIT]; // R2
			end
			if (wr_thresh & w_strb_q[0]) begin
				cfg_q.start_threshold_percent <= thr_sat;
			end
			if (wr_hyst & w_strb_q[0]) begin
				cfg_q.dropoff_hysteresis_percent <= hyst_sat;
			end
			if (wr_delay) begin
				cfg_q.operate_delay_ms <= dly_sat;
			end
		end
	end

	// axi read path: one outstanding read, answered one cycle later
	assign s_axi_arready = ~rvalid_q;
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};

	logic [31:0] status_word;
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`STAT_START_LSB +: 3] = start_q;
		status_word[`STAT_TRIP_LSB +: 3] = ph_trip;
		status_word[`STAT_GENST_BIT] = gen_start_q;
		status_word[`STAT_GENTR_BIT] = gen_trip_q;
		status_word[`STAT_BLOCK_BIT] = user_block_input;
	end

	wire [31:0] ctrl_word = {29'h0, cfg_q.line_to_line_mode,
		cfg_q.start_without_trip_select, cfg_q.function_enable_setting};

	wire rd_ctrl = (rd_addr == `ADDR_CTRL);
	wire rd_thresh = (rd_addr == `ADDR_THRESH);
	wire rd_hyst = (rd_addr == `ADDR_HYST);
	wire rd_delay = (rd_addr == `ADDR_DELAY);
	wire rd_status = (rd_addr == `ADDR_STATUS);
	wire rd_mapped = rd_ctrl | rd_thresh | rd_hyst | rd_delay | rd_status;

	wire [31:0] rd_mux =
		rd_ctrl ? ctrl_word :
		rd_thresh ? {24'h0, cfg_q.start_threshold_percent} :
		rd_hyst ? {28'h0, cfg_q.dropoff_hysteresis_percent} :
		rd_delay ? {16'h0, cfg_q.operate_delay_ms} :
		rd_status ? status_word : 32'h0000_0000;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rvalid_q <= 1'h0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `RESP_OKAY;
		end else if (ar_take) begin
			rvalid_q <= 1'h1;
			rdata_q <= rd_mux;
			rresp_q <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'h0;
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

endmodule

/* sim/ovp_mag_src.sv */
`timescale 1ns/1ps
module ovp_mag_src (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// requested codes, phase a in the low half-word
	input wire logic [2:0][15:0] level,
	// rms fundamental magnitudes, per phase or per phase pair
	output logic [15:0] phase_a_rms_magnitude,
	output logic [15:0] phase_b_rms_magnitude,
	output logic [15:0] phase_c_rms_magnitude
);
	// upstream refreshes once a cycle; the fourier work is not modelled
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phase_a_rms_magnitude <= 16'h0;
			phase_b_rms_magnitude <= 16'h0;
			phase_c_rms_magnitude <= 16'h0;
		end else begin
			phase_a_rms_magnitude <= level[0];
			phase_b_rms_magnitude <= level[1];
			phase_c_rms_magnitude <= level[2];
		end
	end
endmodule

/* sim/ovp_top_assertions.sv */
`timescale 1ns/1ps
module ovp_top_assertions (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// bus handshakes
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// protection
	input wire logic user_block_input,
	input wire logic phase_a_start_flag,
	input wire logic phase_b_start_flag,
	input wire logic phase_c_start_flag,
	input wire logic any_phase_start,
	input wire logic overall_trip_command
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire [2:0] st = {phase_c_start_flag, phase_b_start_flag,
		phase_a_start_flag};
	property p_gen_start;
		(|st) |-> ##[0:1] any_phase_start;
	endproperty
	a_gen_start: assert property (p_gen_start)
		else $error("general start missing");
	// one edge for the block to land, then all outputs quiet
	property p_block;
		user_block_input ##1 user_block_input |=>
			!(|st) && !any_phase_start && !overall_trip_command;
	endproperty
	a_block: assert property (p_block)
		else $error("output active while blocked");
	property p_trip_start;
		$rose(overall_trip_command) |-> any_phase_start;
	endproperty
	a_trip_start: assert property (p_trip_start)
		else $error("trip without start");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped");
	property p_ar_refuse;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_refuse: assert property (p_ar_refuse)
		else $error("read address taken while busy");
	property p_aw_refuse;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_aw_refuse: assert property (p_aw_refuse)
		else $error("write taken while response pending");
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat)
		else $error("read answer late");
endmodule

/* sim/ovp_top_tb.sv */
`timescale 1ns/1ps
module ovp_top_tb;
	import ovp_pkg::*;
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	logic [7:0] s_axi_awaddr = 8'h0;
	logic [7:0] s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0;
	logic s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0;
	logic user_block_input = 1'h0;
	logic [2:0][15:0] level = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, phase_a_start_flag, phase_b_start_flag;
	logic phase_c_start_flag, any_phase_start, overall_trip_command;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, rd;
	logic [15:0] phase_a_rms_magnitude, phase_b_rms_magnitude;
	logic [15:0] phase_c_rms_magnitude;
	wire [31:0] outs = {27'h0, overall_trip_command, any_phase_start,
		phase_c_start_flag, phase_b_start_flag, phase_a_start_flag};
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	// short millisecond so delays stay within a few dozen cycles
	ovp_top #(.CYCLES_PER_MS(10)) u_ovp_top (.ref_clk, .rst,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .phase_a_rms_magnitude, .phase_b_rms_magnitude,
		.phase_c_rms_magnitude, .user_block_input, .phase_a_start_flag,
		.phase_b_start_flag, .phase_c_start_flag, .any_phase_start,
		.overall_trip_command);
	ovp_mag_src u_ovp_mag_src (.ref_clk, .rst, .level,
		.phase_a_rms_magnitude, .phase_b_rms_magnitude,
		.phase_c_rms_magnitude);
	initial forever #20 ref_clk = ~ref_clk;
	task automatic conclude();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_done = 1'h0;
		logic w_done = 1'h0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(aw_done && w_done)) begin
			@(posedge ref_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
			aw_done |= s_axi_awready;
			w_done |= s_axi_wready;
		end
		while (!s_axi_bvalid)
			@(posedge ref_clk);
		s_axi_bready <= 1'h0;
		resp = s_axi_bresp;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge ref_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge ref_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		rd = s_axi_rdata;
		resp = s_axi_rresp;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rd_reg(a);
		check(rd, exp);
	endtask
	task automatic set_lv(input logic [15:0] a, b, c);
		@(posedge ref_clk);
		level <= {c, b, a};
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			conclude();
		end
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'h0;
		rchk(8'h00, 32'h0);
		rchk(8'h04, 32'h6e);
		rchk(8'h08, 32'h5);
		rchk(8'h0c, 32'h64);
		rchk(8'h14, 32'h0);
		check({30'h0, resp}, 32'h2);
		wr(8'h14, 32'h0);
		check({30'h0, resp}, 32'h2);
		// status is read only: write is answered but changes nothing
		wr(8'h10, 32'h1ff);
		check({30'h0, resp}, 32'h0);
		rchk(8'h10, 32'h0);
		wr(8'h0c, 32'hffff);
		rchk(8'h0c, 32'hea60);
		wr(8'h04, 32'h10);
		rchk(8'h04, 32'h1e);
		wr(8'h08, 32'hff);
		rchk(8'h08, 32'ha);
		// overvoltage while off stays silent
		set_lv(16'h2ee0, 16'h2ee0, 16'h2ee0);
		repeat (8) @(posedge ref_clk);
		check(outs, 32'h0);
		// clear levels first, or enabling starts every phase at once
		set_lv(16'h0, 16'h0, 16'h0);
		wr(8'h08, 32'h5);
		wr(8'h04, 32'h6e);
		wr(8'h00, 32'h1);
		set_lv(16'h2af8, 16'h0, 16'h0);
		repeat (8) @(posedge ref_clk);
		check(outs, 32'h0);
		set_lv(16'h2b5c, 16'h0, 16'h0);
		repeat (4) @(posedge ref_clk);
		check(outs, 32'h9);
		// 10450 is exactly the drop level, so it holds
		set_lv(16'h28d2, 16'h0, 16'h0);
		repeat (8) @(posedge ref_clk);
		check(outs, 32'h9);
		set_lv(16'h28d1, 16'h0, 16'h0);
		repeat (8) @(posedge ref_clk);
		check(outs, 32'h0);
		set_lv(16'h0, 16'h2b5c, 16'h0);
		repeat (4) @(posedge ref_clk);
		check(outs, 32'ha);
		set_lv(16'h0, 16'h0, 16'h0);
		wr(8'h0c, 32'h3);
		set_lv(16'h0, 16'h0, 16'h2b5c);
		repeat (20) @(posedge ref_clk);
		set_lv(16'h0, 16'h0, 16'h0);
		repeat (6) @(posedge ref_clk);
		set_lv(16'h0, 16'h0, 16'h2b5c);
		repeat (28) @(posedge ref_clk);
		check(outs, 32'hc);
		repeat (12) @(posedge ref_clk);
		check(outs, 32'h1c);
		rchk(8'h10, 32'he4);
		wr(8'h00, 32'h3);
		repeat (4) @(posedge ref_clk);
		check(outs, 32'hc);
		rchk(8'h10, 32'h64);
		user_block_input <= 1'h1;
		repeat (4) @(posedge ref_clk);
		check(outs, 32'h0);
		rchk(8'h10, 32'h100);
		user_block_input <= 1'h0;
		repeat (4) @(posedge ref_clk);
		check(outs, 32'hc);
		wr(8'h00, 32'h0);
		repeat (4) @(posedge ref_clk);
		check(outs, 32'h0);
		wr(8'h0c, 32'h0);
		wr(8'h00, 32'h1);
		repeat (4) @(posedge ref_clk);
		check(outs, 32'h1c);
		// pair mode only relabels the flags, behaviour stays the same
		wr(8'h00, 32'h5);
		check({30'h0, resp}, 32'h0);
		repeat (4) @(posedge ref_clk);
		check(outs, 32'h1c);
		rchk(8'h00, 32'h5);
		conclude();
	end
endmodule

bind ovp_top ovp_top_assertions u_ovp_top_assertions (.ref_clk, .rst,
	.s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.user_block_input, .phase_a_start_flag, .phase_b_start_flag,
	.phase_c_start_flag, .any_phase_start, .overall_trip_command);
